// *** shared/rspso_pkg.sv ***
// Constants for the receive-channel serial output port.
// Assumes a 32-bit AHB-Lite register bus and a single system clock.
package rspso_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0]  FOC_IDX        = 8'hA4;
    localparam logic [7:0]  SPC_IDX        = 8'hA9;
    localparam logic [7:0]  STS_IDX        = 8'hB0;
    localparam logic [7:0]  FRC_IDX        = 8'hB1;
    localparam logic [9:0]  FOC_ADDR       = {FOC_IDX, 2'b00};
    localparam logic [9:0]  SPC_ADDR       = {SPC_IDX, 2'b00};
    localparam logic [9:0]  STS_ADDR       = {STS_IDX, 2'b00};
    localparam logic [9:0]  FRC_ADDR       = {FRC_IDX, 2'b00};
    // Register widths and reset values
    localparam int          FOC_W          = 11;
    localparam int          SPC_W          = 5;
    localparam int          FRC_W          = 16;
    localparam int          STS_W          = 4;
    localparam logic [10:0] FOC_RST        = 11'h000;
    localparam logic [4:0]  SPC_RST        = 5'h01;
    localparam logic [15:0] FRC_RST        = 16'h0000;
    // Field positions
    localparam int          FOC_FMT_LSB    = 4;
    localparam int          FOC_CEXP_BIT   = 7;
    localparam int          SPC_MASTER_BIT = 4;
    localparam int          FRC_PREC_LSB   = 0;
    localparam int          FRC_STYLE_LSB  = 2;
    localparam int          FRC_DECIM_LSB  = 8;
    // Output formats
    localparam logic [1:0]  FMT_FIXED      = 2'h0;
    localparam logic [1:0]  FMT_FP84       = 2'h1;
    // Word and frame lengths
    localparam logic [5:0]  WLEN_12        = 6'h0C;
    localparam logic [5:0]  WLEN_16        = 6'h10;
    localparam logic [5:0]  WLEN_24        = 6'h18;
    localparam logic [5:0]  COMPACT_BITS   = 6'h14;
    localparam logic [7:0]  COMPACT_DECIM  = 8'h14;
    localparam logic [3:0]  DIV_MIN        = 4'h1;

    typedef enum logic [1:0] {
        FS_BEFORE   = 2'h0,
        FS_DURING   = 2'h1,
        FS_PER_WORD = 2'h2
    } rspso_fs_style_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_PRE   = 3'h2,
        ST_SHIFT = 3'h4
    } rspso_state_t;
endpackage

// *** logic/rspso_sclk_gen.sv ***
// Serial clock divider for master operation.
// Assumes the divider value is stable while enabled.
`timescale 1ns/1ns
module rspso_sclk_gen (
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       en_i,
    input  wire logic [3:0] div_i,
    output logic            tick_o,
    output logic            sclk_o
);
    logic [3:0] cnt;
    logic [3:0] next_cnt;

    // Period of div + 1 system clocks; tick on the rising sclk edge
    always_comb begin
        next_cnt = (cnt >= div_i) ? 4'h0 : cnt + 4'h1;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt    <= 4'h0;
            sclk_o <= 1'b0;
        end else if (!en_i) begin
            cnt    <= 4'h0;
            sclk_o <= 1'b0;
        end else begin
            cnt    <= next_cnt;
            sclk_o <= (next_cnt <= (div_i >> 1));
        end
    end

    assign tick_o = en_i && (cnt >= div_i);
endmodule

// *** logic/rspso_ahb_regs.sv ***
// AHB-Lite register slave for the serial output port.
// Zero wait states, OKAY only; decodes haddr[9:0], word accesses.
`timescale 1ns/1ns
module rspso_ahb_regs (
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    input  wire logic [3:0]  status_i,
    output logic [31:0]      hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [10:0]      foc_o,
    output logic [4:0]       spc_o,
    output logic [15:0]      frc_o
);
    logic        wr_pend;
    logic [9:0]  wr_addr;
    logic [10:0] next_foc;
    logic [4:0]  next_spc;
    logic [15:0] next_frc;
    logic [31:0] rd_val;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_pend <= 1'b0;
            wr_addr <= 10'h000;
        end else if (hready_i) begin
            wr_pend <= hsel_i && htrans_i[1] && hwrite_i;
            wr_addr <= haddr_i[9:0];
        end
    end

    // Write data lands in the data phase; reads see it at once
    always_comb begin
        next_foc = foc_o;
        next_spc = spc_o;
        next_frc = frc_o;
        if (wr_pend && wr_addr == rspso_pkg::FOC_ADDR) begin
            next_foc = hwdata_i[10:0];
        end
        if (wr_pend && wr_addr == rspso_pkg::SPC_ADDR) begin
            next_spc = hwdata_i[4:0];
        end
        if (wr_pend && wr_addr == rspso_pkg::FRC_ADDR) begin
            next_frc = hwdata_i[15:0];
        end
        case (haddr_i[9:0])
            rspso_pkg::FOC_ADDR: rd_val = {21'h000000, next_foc};
            rspso_pkg::SPC_ADDR: rd_val = {27'h0000000, next_spc};
            rspso_pkg::FRC_ADDR: rd_val = {16'h0000, next_frc};
            rspso_pkg::STS_ADDR: rd_val = {28'h0000000, status_i};
            default:             rd_val = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            foc_o <= rspso_pkg::FOC_RST;
            spc_o <= rspso_pkg::SPC_RST;
            frc_o <= rspso_pkg::FRC_RST;
        end else begin
            foc_o <= next_foc;
            spc_o <= next_spc;
            frc_o <= next_frc;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hrdata_o    <= 32'h00000000;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
                hrdata_o <= rd_val;
            end
        end
    end
endmodule

// *** logic/rspso_top.sv ***
// Serial output port of one receive channel.
// Assumes samples arrive as one-cycle strobes and pins are synchronous.
`timescale 1ns/1ns
module rspso_top #(
    parameter int PORT_INDEX = 0
) (
    input  wire logic        SYS_CLK_I,
    input  wire logic        ARST_N_I,
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic      [31:0] HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    input  wire logic        PORT0_MASTER_PIN_I,
    input  wire logic [3:0]  PORT0_DIVIDER_PINS_I,
    input  wire logic        SAMPLE_VALID_I,
    input  wire logic [23:0] SAMPLE_I_I,
    input  wire logic [23:0] SAMPLE_Q_I,
    input  wire logic [3:0]  EXP_I_I,
    input  wire logic [3:0]  EXP_Q_I,
    input  wire logic        SCLK_I,
    input  wire logic        FRAME_SYNC_I,
    output logic             SCLK_O,
    output logic             SCLK_OE_O,
    output logic             FRAME_SYNC_O,
    output logic             FRAME_SYNC_OE_O,
    output logic             SERIAL_DATA_O,
    output logic             FRAME_END_O,
    output logic             CHANNEL_DATA_READY_O
);
    logic [10:0]               foc;
    logic [4:0]                spc;
    logic [15:0]               frc;
    logic                      master_role;
    logic                      pin_taken;
    logic [3:0]                div_raw;
    logic [3:0]                div_eff;
    logic                      mtick;
    logic                      sclk_prev;
    logic                      tick;
    logic [1:0]                fmt;
    logic                      cexp;
    logic                      compact;
    logic [23:0]               buf_i;
    logic [23:0]               buf_q;
    logic                      buf_full;
    logic                      start;
    logic                      chain;
    logic                      take;
    rspso_pkg::rspso_state_t   state;
    rspso_pkg::rspso_fs_style_t style;
    rspso_pkg::rspso_fs_style_t style_q;
    logic                      compact_q;
    logic [5:0]                wlen;
    logic [5:0]                total;
    logic [5:0]                next_wlen;
    logic [5:0]                em;
    logic [23:0]               i_sh;
    logic [23:0]               q_sh;
    logic                      cur_bit;
    logic                      last_bit;
    logic                      fs_out;
    logic                      fe_out;
    logic                      data_out;

    // Mantissa and exponent packing, left justified in 24 bits
    function automatic logic [23:0] pack_word(input logic [23:0] s,
                                              input logic [3:0]  e,
                                              input logic [1:0]  f);
        logic [23:0] w;
        w = s;
        if (f[1]) begin
            w = {s[23:12], e, 8'h00};
        end else if (f == rspso_pkg::FMT_FP84) begin
            w = {s[23:16], e, 12'h000};
        end
        return w;
    endfunction

    function automatic logic [5:0] word_len(input logic [1:0] p);
        logic [5:0] l;
        l = rspso_pkg::WLEN_24;
        if (p == 2'h0) begin
            l = rspso_pkg::WLEN_12;
        end else if (p == 2'h1) begin
            l = rspso_pkg::WLEN_16;
        end
        return l;
    endfunction

    rspso_ahb_regs u_regs (
        .clk_i       (SYS_CLK_I),
        .arst_n_i    (ARST_N_I),
        .hsel_i      (HSEL_I),
        .haddr_i     (HADDR_I),
        .htrans_i    (HTRANS_I),
        .hwrite_i    (HWRITE_I),
        .hwdata_i    (HWDATA_I),
        .hready_i    (HREADY_I),
        .status_i    ({state != rspso_pkg::ST_IDLE, compact, master_role,
                       buf_full}),
        .hrdata_o    (HRDATA_O),
        .hreadyout_o (HREADYOUT_O),
        .hresp_o     (HRESP_O),
        .foc_o       (foc),
        .spc_o       (spc),
        .frc_o       (frc)
    );

    // Role: port 0 caught from its pin after reset, others from config
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            master_role <= 1'b0;
            pin_taken   <= 1'b0;
        end else if (PORT_INDEX == 0) begin
            pin_taken <= 1'b1;
            if (!pin_taken) begin
                master_role <= PORT0_MASTER_PIN_I;
            end
        end else begin
            master_role <= spc[rspso_pkg::SPC_MASTER_BIT];
        end
    end

    assign SCLK_OE_O       = master_role;
    assign FRAME_SYNC_OE_O = master_role;

    // Divider source and clamp to the smallest legal value
    assign div_raw = (PORT_INDEX == 0) ? PORT0_DIVIDER_PINS_I
                                       : spc[3:0];
    assign div_eff = (div_raw == 4'h0) ? rspso_pkg::DIV_MIN : div_raw;

    rspso_sclk_gen u_sclk (
        .clk_i    (SYS_CLK_I),
        .arst_n_i (ARST_N_I),
        .en_i     (master_role),
        .div_i    (div_eff),
        .tick_o   (mtick),
        .sclk_o   (SCLK_O)
    );

    // Slave clock edge found by sampling against the system clock
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            sclk_prev <= 1'b0;
        end else begin
            sclk_prev <= SCLK_I;
        end
    end

    assign tick = master_role ? mtick
                              : (SCLK_I && !sclk_prev);

    // Configuration decode
    assign fmt     = foc[rspso_pkg::FOC_FMT_LSB +: 2];
    assign cexp    = foc[rspso_pkg::FOC_CEXP_BIT];
    assign style   = rspso_pkg::rspso_fs_style_t'(
                         frc[rspso_pkg::FRC_STYLE_LSB +: 2]);
    assign compact = (frc[rspso_pkg::FRC_DECIM_LSB +: 8] ==
                      rspso_pkg::COMPACT_DECIM) &&
                     (fmt == rspso_pkg::FMT_FP84) && cexp;
    assign next_wlen = compact ? rspso_pkg::WLEN_12
                               : word_len(frc[rspso_pkg::FRC_PREC_LSB +: 2]);

    // Serial buffer; a new sample wins over the take in the same cycle
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            buf_i    <= 24'h000000;
            buf_q    <= 24'h000000;
            buf_full <= 1'b0;
        end else if (SAMPLE_VALID_I) begin
            buf_i    <= pack_word(SAMPLE_I_I, EXP_I_I, fmt);
            buf_q    <= pack_word(SAMPLE_Q_I,
                                  cexp ? EXP_I_I : EXP_Q_I, fmt);
            buf_full <= 1'b1;
        end else if (take) begin
            buf_full <= 1'b0;
        end
    end

    assign CHANNEL_DATA_READY_O = buf_full;

    // Frame start and back-to-back compact chaining
    assign start = buf_full && (master_role || FRAME_SYNC_I);
    assign last_bit = (em == total - 6'h01);
    assign chain = (state == rspso_pkg::ST_SHIFT) && (em == total) &&
                   compact_q && buf_full && master_role;
    assign take  = tick && (chain ||
                   ((state == rspso_pkg::ST_IDLE) && start));
    assign cur_bit = (em < wlen) ? i_sh[23] : q_sh[23];

    // Shifter, frame sync and frame end, all moving on serial edges
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state     <= rspso_pkg::ST_IDLE;
            style_q   <= rspso_pkg::FS_BEFORE;
            compact_q <= 1'b0;
            wlen      <= rspso_pkg::WLEN_12;
            total     <= rspso_pkg::COMPACT_BITS;
            em        <= 6'h00;
            i_sh      <= 24'h000000;
            q_sh      <= 24'h000000;
            fs_out    <= 1'b0;
            fe_out    <= 1'b0;
            data_out  <= 1'b0;
        end else if (tick) begin
            case (state)
                rspso_pkg::ST_IDLE: begin
                    fe_out <= 1'b0;
                    if (start) begin
                        style_q   <= style;
                        compact_q <= compact;
                        wlen      <= next_wlen;
                        total     <= compact ? rspso_pkg::COMPACT_BITS
                                 : {next_wlen[4:0], 1'b0};
                        if (master_role &&
                            style == rspso_pkg::FS_DURING) begin
                            data_out <= buf_i[23];
                            i_sh     <= {buf_i[22:0], 1'b0};
                            q_sh     <= buf_q;
                            em       <= 6'h01;
                            fs_out   <= 1'b1;
                            state    <= rspso_pkg::ST_SHIFT;
                        end else begin
                            i_sh   <= buf_i;
                            q_sh   <= buf_q;
                            em     <= 6'h00;
                            fs_out <= master_role;
                            state  <= rspso_pkg::ST_PRE;
                        end
                    end else begin
                        fs_out   <= 1'b0;
                        data_out <= 1'b0;
                    end
                end
                rspso_pkg::ST_PRE: begin
                    data_out <= i_sh[23];
                    i_sh     <= {i_sh[22:0], 1'b0};
                    em       <= 6'h01;
                    fs_out   <= 1'b0;
                    state    <= rspso_pkg::ST_SHIFT;
                end
                rspso_pkg::ST_SHIFT: begin
                    if (em == total) begin
                        fe_out <= 1'b0;
                        if (chain) begin
                            data_out <= buf_i[23];
                            i_sh     <= {buf_i[22:0], 1'b0};
                            q_sh     <= buf_q;
                            em       <= 6'h01;
                            fs_out   <= style_q == rspso_pkg::FS_DURING;
                        end else begin
                            data_out <= 1'b0;
                            fs_out   <= 1'b0;
                            em       <= 6'h00;
                            state    <= rspso_pkg::ST_IDLE;
                        end
                    end else begin
                        data_out <= cur_bit;
                        if (em < wlen) begin
                            i_sh <= {i_sh[22:0], 1'b0};
                        end else begin
                            q_sh <= {q_sh[22:0], 1'b0};
                        end
                        em     <= em + 6'h01;
                        fe_out <= last_bit;
                        fs_out <= master_role &&
                            ((style_q == rspso_pkg::FS_DURING) ||
                             (style_q == rspso_pkg::FS_PER_WORD &&
                              em == wlen - 6'h01) ||
                             (last_bit && compact_q && buf_full));
                    end
                end
                default: begin
                    state <= rspso_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign FRAME_SYNC_O  = fs_out;
    assign FRAME_END_O   = fe_out;
    assign SERIAL_DATA_O = data_out;

    AST_DR_AFTER_SAMPLE: assert property (
        @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
        SAMPLE_VALID_I |=> CHANNEL_DATA_READY_O)
        else $error("data ready not raised after sample");

    AST_FE_ONE_CYCLE: assert property (
        @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
        (FRAME_END_O && tick) |=> !FRAME_END_O)
        else $error("frame end held past one serial cycle");

    AST_FE_ON_LAST: assert property (
        @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
        (tick && state == rspso_pkg::ST_SHIFT && em != total &&
         last_bit) |=> FRAME_END_O)
        else $error("frame end missing on last bit");

    AST_OE_ROLE: assert property (
        @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
        (PORT_INDEX != 0 && !spc[rspso_pkg::SPC_MASTER_BIT])
        |=> (!SCLK_OE_O && !FRAME_SYNC_OE_O))
        else $error("slave port drives clock or sync");

    AST_PRE_TO_SHIFT: assert property (
        @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
        (state == rspso_pkg::ST_PRE && tick)
        |=> (state == rspso_pkg::ST_SHIFT && em == 6'h01))
        else $error("shift did not start after sync cycle");

    AST_FS_BEFORE: assert property (
        @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
        (master_role && state == rspso_pkg::ST_PRE) |-> FRAME_SYNC_O)
        else $error("frame sync low in cycle before data");

    AST_FS_DURING: assert property (
        @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
        (master_role && style_q == rspso_pkg::FS_DURING &&
         state == rspso_pkg::ST_SHIFT) |-> FRAME_SYNC_O)
        else $error("frame sync low while shifting");

    AST_SCLK_DIV2: assert property (
        @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
        (master_role && mtick && div_eff == 4'h2 && $stable(div_eff))
        |=> !mtick ##1 !mtick ##1 mtick)
        else $error("serial clock period wrong for divider 2");

    AST_MSB_FIRST: assert property (
        @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
        (state == rspso_pkg::ST_PRE && tick)
        |=> SERIAL_DATA_O == $past(i_sh[23]))
        else $error("first bit is not the word MSB");

    AST_COMPACT_BUSY: assert property (
        @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
        (tick && chain) |=> (state == rspso_pkg::ST_SHIFT &&
                             em == 6'h01))
        else $error("compact frame did not follow without gap");

    COV_FRAME_END: cover property (
        @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
        $rose(FRAME_END_O));

    COV_COMPACT_CHAIN: cover property (
        @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
        tick && chain);

    COV_SLAVE_START: cover property (
        @(posedge SYS_CLK_I) disable iff (!ARST_N_I)
        !master_role && take);
endmodule

// *** bench/rspso_dsp_model.sv ***
// DSP-side serial receiver model for the output port.
// Assumes the serial clock is at most half the system clock.
`timescale 1ns/1ns
module rspso_dsp_model (
    input  wire logic clk_i,
    input  wire logic sclk_i,
    input  wire logic fs_i,
    input  wire logic sdo_i,
    input  wire logic fe_i
);
    logic       sclk_q = 1'b0;
    logic [2:0] rx_q[$];
    // Capture sync, data and frame end at each rising serial clock
    always @(posedge clk_i) begin
        sclk_q <= sclk_i;
        if (sclk_i && !sclk_q) rx_q.push_back({fs_i, sdo_i, fe_i});
    end
endmodule

// *** bench/rsp_serial_output_port_tb.sv ***
// Self-checking bench for the serial output port in master role.
// Assumes zero-wait AHB-Lite registers and the DSP capture model.
`timescale 1ns/1ns
module rsp_serial_output_port_tb;
    logic        clk = 0, rst_n = 0, hsel = 0, hwrite = 0, sv = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0]  htrans = 0;
    logic        hready, sclk, fs, serial_data_out, fe, oe, hresp, fsoe, dr;
    logic [3:0]  div = 0, ei = 0, eq = 0;
    logic [23:0] si = 0, sq = 0;
    int          num_errors = 0, cmp_count = 0;
    always #2 clk = ~clk;
    rspso_top uut (.SYS_CLK_I(clk), .ARST_N_I(rst_n), .HSEL_I(hsel),
        .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
        .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
        .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
        .PORT0_MASTER_PIN_I(1'b1), .PORT0_DIVIDER_PINS_I(div),
        .SAMPLE_VALID_I(sv), .SAMPLE_I_I(si), .SAMPLE_Q_I(sq),
        .EXP_I_I(ei), .EXP_Q_I(eq), .SCLK_I(1'b0), .FRAME_SYNC_I(1'b0),
        .SCLK_O(sclk), .SCLK_OE_O(oe), .FRAME_SYNC_O(fs),
        .FRAME_SYNC_OE_O(fsoe), .SERIAL_DATA_O(serial_data_out), .FRAME_END_O(fe),
        .CHANNEL_DATA_READY_O(dr));
    rspso_dsp_model dsp (.clk_i(clk), .sclk_i(sclk), .fs_i(fs),
        .sdo_i(serial_data_out), .fe_i(fe));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %0h expected %0h",
                     $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        if (num_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic ahb(input logic wr, input logic [9:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {22'h000000, a};
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1 && ++n < 100);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1 && ++n < 100);
        rd = hrdata;
    endtask
    task automatic frame(input int s);
        int         w, off, n, j, nb;
        longint     v;
        logic [2:0] e;
        w = (s == 1) ? 16 : (s == 2) ? 24 : 12;
        off = (s == 1) ? 0 : 1;
        nb = (s == 4) ? 20 : 2 * w;
        ahb(1'b1, rspso_pkg::FOC_ADDR,
            (s == 4) ? 32'h90 : (s == 3) ? 32'h10 : 32'h0);
        ahb(1'b1, rspso_pkg::FRC_ADDR,
            (s == 4) ? 32'h1400 : 32'((s % 3) * 5));
        si <= 24'($urandom);
        sq <= 24'($urandom);
        ei <= 4'($urandom);
        eq <= 4'($urandom);
        sv <= 1'b1;
        @(posedge clk);
        sv <= 1'b0;
        @(negedge clk);
        check(dr, 1'b1);
        v = (s == 4) ? {si[23:16], ei, sq[23:16]}
          : (s == 3) ? {si[23:16], ei, sq[23:16], eq}
                     : ((si >> (24 - w)) << w) | (sq >> (24 - w));
        if (s == 4) begin
            repeat (10) @(posedge clk);
            si <= 24'($urandom);
            sv <= 1'b1;
            @(posedge clk);
            sv <= 1'b0;
        end
        n = 0;
        while (n < 4000 && (dsp.rx_q.size() < nb + 2
               || dsp.rx_q[0][2] !== 1'b1)) begin
            if (dsp.rx_q.size() > 0 && dsp.rx_q[0][2] !== 1'b1)
                void'(dsp.rx_q.pop_front());
            @(posedge clk);
            n++;
        end
        if (n == 4000) num_errors++;
        for (int k = 0; k < nb + off + 1; k++) begin
            e = dsp.rx_q.pop_front();
            j = k - off;
            check(e[2], (s == 1) ? j < nb : k == 0 || (s == 2 && k == w)
                  || (s == 4 && j == nb - 1));
            check(e[0], j == nb - 1);
            if (j >= 0 && j < nb) check(e[1], (v >> (nb - 1 - j)) & 1);
            if (s == 4 && j == nb) check(e[1], si[23]);
        end
        check(dr, 1'b0);
    endtask
    initial begin
        void'($urandom(45257));
        div = 4'($urandom_range(3, 1));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        ahb(1'b0, rspso_pkg::FOC_ADDR, 32'h0);
        check(rd, 32'(rspso_pkg::FOC_RST));
        check(hresp, 1'b0);
        ahb(1'b1, rspso_pkg::SPC_ADDR, 32'hFFFFFFFF);
        ahb(1'b0, rspso_pkg::SPC_ADDR, 32'h0);
        check(rd, 32'h0000001F);
        ahb(1'b0, 10'h3FC, 32'h0);
        check(rd, 32'h0);
        ahb(1'b0, rspso_pkg::STS_ADDR, 32'h0);
        check(rd[1], 1'b1);
        check(oe, 1'b1);
        check(fsoe, 1'b1);
        for (int s = 0; s < 5; s++) frame(s);
        end_sim;
    end
    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        end_sim;
    end
endmodule
